// file: hw/prs_por_seq.sv
// power-on and pin-driven reset sequencer of a configuration memory
// assumes power-good inputs and pins synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "prs_map.svh"

module prs_por_seq
  import prs_pkg::*;
#(
  parameter bit PARALLEL = 1'b1,
  parameter int RELEASE_CYCLES = `PRS_RELEASE_CYCLES,
  parameter int PULSE_LOW_CYCLES = `PRS_PULSE_LOW_CYCLES,
  parameter int ADDR_W = 24
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // supply monitors
  input wire logic coreGood,
  input wire logic outGood,
  // open-drain release line
  input wire logic oeResetIn_n,
  output logic oeResetOut,
  output logic oeResetOe,
  // chip enable
  input wire logic chipEnable_n,
  output logic chipEnableOut_n,
  // configuration pulse pin, open drain with brief high drive
  input wire logic configPulseIn_n,
  output logic configPulseOut_n,
  output logic configPulseOe,
  // configuration instruction from the test port
  input wire logic configTrigger,
  // data path
  input wire logic addrAdvance,
  output logic [ADDR_W-1:0] readAddr,
  output logic dataOe,
  output logic revisionReset,
  output logic inReset
);

  prs_state_t state;
  prs_cf_t cfState;
  logic [31:0] delayCnt;
  logic [31:0] pulseCnt;
  logic powerGood;
  logic pinReset;

  assign powerGood = PARALLEL ? (coreGood && outGood) : coreGood;
  assign pinReset = !oeResetIn_n || chipEnable_n || (PARALLEL && !configPulseIn_n);

  // ----------------------------------------
  // power-on sequence
  // ----------------------------------------
  // restart on power drop
  always_ff @(posedge ref_clk)
  begin
    if (rst || !powerGood)
    begin
      state <= PRS_POWER_WAIT;
      delayCnt <= 32'h0;
    end
    else
    begin
      case (state)
        PRS_POWER_WAIT:
        begin
          state <= PRS_DELAY;
          delayCnt <= 32'h0;
        end
        PRS_DELAY:
        begin
          if (delayCnt >= 32'(RELEASE_CYCLES - 1))
            state <= PRS_RUN;
          else
            delayCnt <= delayCnt + 32'h1;
        end
        PRS_RUN: state <= PRS_RUN;
        default: state <= PRS_POWER_WAIT;
      endcase
    end
  end

  // drive low until released, never driven high
  assign oeResetOut = 1'b0;
  assign oeResetOe = (state != PRS_RUN);

  // ----------------------------------------
  // reset effects
  // ----------------------------------------
  // reset state of outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst || state != PRS_RUN || pinReset)
    begin
      inReset <= 1'b1;
      readAddr <= ADDR_W'(`PRS_ADDR_RESET);
      chipEnableOut_n <= 1'b1;
      dataOe <= 1'b0;
    end
    else
    begin
      inReset <= 1'b0;
      chipEnableOut_n <= 1'b0;
      dataOe <= 1'b1;
      if (addrAdvance)
        readAddr <= readAddr + ADDR_W'(1);
    end
  end

  // revision reset on low config pin, parallel variant only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      revisionReset <= 1'b0;
    else
      revisionReset <= PARALLEL && !configPulseIn_n;
  end

  // ----------------------------------------
  // configuration pulse
  // ----------------------------------------
  // low, brief high, release
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfState <= PRS_CF_IDLE;
      pulseCnt <= 32'h0;
    end
    else
    begin
      case (cfState)
        PRS_CF_IDLE:
        begin
          pulseCnt <= 32'h0;
          if (configTrigger)
            cfState <= PRS_CF_LOW;
        end
        PRS_CF_LOW:
        begin
          if (pulseCnt >= 32'(PULSE_LOW_CYCLES - 1))
          begin
            cfState <= PRS_CF_HIGH;
            pulseCnt <= 32'h0;
          end
          else
            pulseCnt <= pulseCnt + 32'h1;
        end
        PRS_CF_HIGH:
        begin
          if (pulseCnt >= 32'(`PRS_PULSE_HIGH_CYCLES - 1))
            cfState <= PRS_CF_IDLE;
          else
            pulseCnt <= pulseCnt + 32'h1;
        end
        default: cfState <= PRS_CF_IDLE;
      endcase
    end
  end

  assign configPulseOe = (cfState != PRS_CF_IDLE);
  assign configPulseOut_n = (cfState == PRS_CF_HIGH);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_cfLow;
    cfState == PRS_CF_LOW;
  endsequence
  sequence s_cfLowToHigh;
    s_cfLow ##1 (cfState == PRS_CF_HIGH);
  endsequence
  sequence s_cfBriefHigh;
    (configPulseOe && configPulseOut_n) ##1 !configPulseOe;
  endsequence

  a_ramp_drive_low: assert property (@(posedge ref_clk) disable iff (rst)
    !powerGood |=> oeResetOe && !oeResetOut)
    else $error("release line not driven low while power bad");
  a_release_delay: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state == PRS_RUN) |-> $past(state) == PRS_DELAY && delayCnt >= 32'(RELEASE_CYCLES - 1))
    else $error("release before delay elapsed");
  a_drop_reenter: assert property (@(posedge ref_clk) disable iff (rst)
    (state == PRS_RUN && !powerGood) |=> state == PRS_POWER_WAIT ##1 oeResetOe)
    else $error("power drop did not re-enter reset");
  a_polarity_fixed: assert property (@(posedge ref_clk) disable iff (rst)
    oeResetOe |-> !oeResetOut)
    else $error("release line driven high");
  a_pin_reset: assert property (@(posedge ref_clk) disable iff (rst)
    pinReset |=> inReset)
    else $error("pin reset not entered");
  a_reset_outputs: assert property (@(posedge ref_clk) disable iff (rst)
    inReset |-> readAddr == '0 && chipEnableOut_n && !dataOe)
    else $error("reset output state wrong");
  a_variant_power: assert property (@(posedge ref_clk) disable iff (rst)
    (PARALLEL && !outGood) |=> state == PRS_POWER_WAIT)
    else $error("parallel variant ignored output supply");
  a_serial_power: assert property (@(posedge ref_clk) disable iff (rst)
    (!PARALLEL && coreGood && state == PRS_POWER_WAIT) |=> state == PRS_DELAY)
    else $error("serial variant did not start delay");
  a_cfg_trigger: assert property (@(posedge ref_clk) disable iff (rst)
    (cfState == PRS_CF_IDLE && configTrigger) |=> configPulseOe && !configPulseOut_n)
    else $error("config pulse not started");
  a_cfg_shape: assert property (@(posedge ref_clk) disable iff (rst)
    s_cfLowToHigh |-> s_cfBriefHigh)
    else $error("config pulse shape wrong");
  a_revision_reset: assert property (@(posedge ref_clk) disable iff (rst)
    (PARALLEL && !configPulseIn_n) |=> revisionReset && inReset)
    else $error("low config pin did not reset revision");
  a_delay_restart: assert property (@(posedge ref_clk) disable iff (rst)
    !powerGood |=> delayCnt == 32'h0)
    else $error("delay counter not restarted");

endmodule
`default_nettype wire

// file: hw/prs_map.svh
// constants for the power-on reset sequencer
// assumes inclusion by bare name from design files
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
`define PRS_CLK_PERIOD_NS 8
`define PRS_RELEASE_DELAY_NS 2000
`define PRS_RELEASE_CYCLES ((`PRS_RELEASE_DELAY_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
`define PRS_PULSE_LOW_NS 1000
`define PRS_PULSE_LOW_CYCLES ((`PRS_PULSE_LOW_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
`define PRS_PULSE_HIGH_CYCLES 1
`define PRS_ADDR_RESET 24'h000000
`endif

// file: hw/prs_pkg.sv
// types for the power-on reset sequencer
// assumes no surroundings
package prs_pkg;
  typedef enum logic [1:0] {PRS_POWER_WAIT, PRS_DELAY, PRS_RUN} prs_state_t;
  typedef enum logic [1:0] {PRS_CF_IDLE, PRS_CF_LOW, PRS_CF_HIGH} prs_cf_t;
endpackage

// file: dv/prs_partner.sv
// pull-ups, monitor and target view of the reset sequencer pins
// assumes enables come from prs_por_seq
`timescale 1ns/1ns
`default_nettype none
module prs_partner (
  // sequencer pins
  input wire logic ref_clk,
  input wire logic oeResetOe,
  input wire logic configPulseOut_n,
  input wire logic configPulseOe,
  // supply monitor
  input wire logic monitorHold,
  // wire levels and target release pulse
  output logic oeResetWire,
  output logic configWire,
  output logic targetGo
);
  logic lastWire;
  assign oeResetWire = !(oeResetOe || monitorHold);
  assign configWire = configPulseOe ? configPulseOut_n : 1'b1;
  always_ff @(posedge ref_clk)
  begin
    lastWire <= oeResetWire;
    targetGo <= oeResetWire && !lastWire;
  end
endmodule
`default_nettype wire

// file: dv/prs_por_seq_tb.sv
// self-checking bench for the power-on reset sequencer
// assumes short counts and the pin model prs_partner
`timescale 1ns/1ns
`default_nettype none
module prs_por_seq_tb;
  import prs_pkg::*;
  localparam int RC = 4;
  localparam int PL = 3;
  logic ref_clk, rst, coreGood, outGood, chipEnable_n, configTrigger, addrAdvance, monitorHold;
  logic oeResetWire, configWire, targetGo, oeResetOut, oeResetOe, chipEnableOut_n;
  logic configPulseOut_n, configPulseOe, dataOe, revisionReset, inReset, revSeen;
  logic serOe, serInReset;
  logic [23:0] readAddr;
  logic [7:0] lfsr;
  int mismatches, samples_checked, n, exp;
  prs_por_seq #(.RELEASE_CYCLES(RC), .PULSE_LOW_CYCLES(PL)) i_dut (.ref_clk(ref_clk),
    .rst(rst), .coreGood(coreGood), .outGood(outGood), .oeResetIn_n(oeResetWire),
    .oeResetOut(oeResetOut), .oeResetOe(oeResetOe), .chipEnable_n(chipEnable_n),
    .chipEnableOut_n(chipEnableOut_n), .configPulseIn_n(configWire),
    .configPulseOut_n(configPulseOut_n), .configPulseOe(configPulseOe),
    .configTrigger(configTrigger), .addrAdvance(addrAdvance), .readAddr(readAddr),
    .dataOe(dataOe), .revisionReset(revisionReset), .inReset(inReset));
  prs_partner i_far (.ref_clk(ref_clk), .oeResetOe(oeResetOe),
    .configPulseOut_n(configPulseOut_n), .configPulseOe(configPulseOe),
    .monitorHold(monitorHold), .oeResetWire(oeResetWire), .configWire(configWire),
    .targetGo(targetGo));
  // serial variant, releases on core supply alone
  prs_por_seq #(.PARALLEL(1'b0), .RELEASE_CYCLES(RC), .PULSE_LOW_CYCLES(PL)) i_dut_ser (
    .ref_clk(ref_clk), .rst(rst), .coreGood(coreGood), .outGood(outGood),
    .oeResetIn_n(!serOe), .oeResetOut(), .oeResetOe(serOe), .chipEnable_n(chipEnable_n),
    .chipEnableOut_n(), .configPulseIn_n(configWire), .configPulseOut_n(),
    .configPulseOe(), .configTrigger(configTrigger), .addrAdvance(addrAdvance),
    .readAddr(), .dataOe(), .revisionReset(), .inReset(serInReset));
  function automatic logic [7:0] nxt(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic step(int k = 1);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
  // ----------
  // scenarios
  // ----------
  initial
  begin
    {rst, coreGood, outGood, chipEnable_n, configTrigger, addrAdvance, monitorHold} = 7'h40;
    lfsr = 8'h3b;
    step(5);
    rst = 0;
    coreGood = 1;
    step(RC + 4);
    check(oeResetOe, 1);
    check({serOe, serInReset}, 2'h0);
    check(oeResetOut, 0);
    check({inReset, chipEnableOut_n, dataOe, readAddr}, {3'h6, 24'h000000});
    outGood = 1;
    step(RC);
    check(oeResetOe, 1);
    n = 0;
    while (oeResetOe !== 1'b0 && n < 8)
    begin
      step();
      n++;
    end
    check(n < 4, 1);
    step();
    check({targetGo, inReset}, 2'h2);
    $display("test release done");
    exp = 0;
    repeat (40)
    begin
      lfsr = nxt(lfsr);
      addrAdvance = lfsr[0];
      step();
      exp += lfsr[0];
      check(readAddr, exp);
    end
    addrAdvance = 1;
    for (int c = 0; c < 2; c++)
    begin
      {monitorHold, chipEnable_n} = c ? 2'h2 : 2'h1;
      step(3);
      check({inReset, chipEnableOut_n, dataOe, readAddr}, {3'h6, 24'h000000});
      {monitorHold, chipEnable_n} = 2'h0;
      step(3);
      check(inReset, 0);
    end
    $display("test pin reset done");
    configTrigger = 1;
    step();
    configTrigger = 0;
    n = 0;
    while (configPulseOe !== 1'b1 && n < 3)
    begin
      step();
      n++;
    end
    revSeen = 0;
    for (int i = 0; i <= PL + 1; i++)
    begin
      check({configPulseOe, configPulseOut_n}, i < PL ? 2'h2 : i == PL ? 2'h3 : 2'h0);
      if (i == PL - 1)
        check(inReset, 1);
      revSeen |= revisionReset;
      // a trigger during the pulse must not restart it
      configTrigger = (i == 1);
      step();
    end
    check(revSeen, 1);
    $display("test config pulse done");
    coreGood = 0;
    step(2);
    check(oeResetOe, 1);
    coreGood = 1;
    step(2);
    coreGood = 0;
    step();
    coreGood = 1;
    step(RC);
    check(oeResetOe, 1);
    step(4);
    check(oeResetOe, 0);
    $display("test supply drop done");
    print_verdict();
  end
endmodule
`default_nettype wire
